// >>> rtl/slcal_pkg.sv
// Purpose: shared constants and types of the sleep clock calibration block
// Assumes: 50 MHz aclk, AXI4-Lite register access, 8-bit registers in low bits
// Notes:   register offsets are word indices, byte address is four times the index
package slcal_pkg;

  // bus widths and responses
  localparam int          ADDR_W      = 12;
  localparam int          IDX_W       = 10;
  typedef logic [ADDR_W-1:0] slcal_addr_t;
  typedef logic [31:0]       slcal_data_t;
  typedef logic [IDX_W-1:0]  slcal_idx_t;
  localparam logic [1:0]  RESP_OKAY   = 2'h0;
  localparam logic [1:0]  RESP_SLVERR = 2'h2;

  // register indices
  localparam slcal_idx_t  IDX_SRC_SEL  = 10'h207;
  localparam slcal_idx_t  IDX_CAL_LOW  = 10'h209;
  localparam slcal_idx_t  IDX_CAL_MID  = 10'h20a;
  localparam slcal_idx_t  IDX_STATUS   = 10'h20b;
  localparam slcal_idx_t  IDX_RADIO    = 10'h20f;
  localparam slcal_idx_t  IDX_DIVISOR  = 10'h220;
  localparam slcal_idx_t  IDX_INT_STAT = 10'h300;
  localparam slcal_idx_t  IDX_INT_MASK = 10'h301;

  // field positions
  localparam int          DONE_BIT    = 7;
  localparam int          START_BIT   = 4;
  localparam int          SEL_LSB     = 6;
  localparam int          RADIO_LSB   = 5;
  localparam int          INT_DONE    = 0;

  // field widths and reset values
  localparam int          CNT_W       = 20;
  localparam int          SEL_W       = 2;
  localparam int          DIV_W       = 5;
  localparam int          PER_W       = 4;
  localparam int          EDGE_W      = 31;
  localparam logic [SEL_W-1:0] SEL_RESET = 2'h0;
  localparam logic [DIV_W-1:0] DIV_RESET = 5'h00;
  localparam logic [CNT_W-1:0] CNT_MAX   = 20'hfffff;

  // sleep source codes
  localparam logic [SEL_W-1:0] SRC_INT  = 2'h2;
  localparam logic [SEL_W-1:0] SRC_EXT  = 2'h1;

  // sixteen sleep periods per measurement
  localparam int               PERIODS     = 16;
  localparam logic [PER_W-1:0] LAST_PERIOD = PER_W'(PERIODS - 1);

  // reference tick timing
  localparam int          CLK_PERIOD_NS = 20;
  localparam int          TICK_NS       = 50;
  localparam int          PH_W          = 6;
  localparam logic [PH_W-1:0] PH_STEP   = PH_W'(CLK_PERIOD_NS);
  localparam logic [PH_W-1:0] PH_WRAP   = PH_W'(TICK_NS);

  // calibration control states
  typedef enum logic [2:0] {
    ST_IDLE  = 3'b001,
    ST_ARM   = 3'b010,
    ST_COUNT = 3'b100
  } slcal_state_t;

  // radio state machine codes
  typedef enum logic [2:0] {
    RS_RESET      = 3'h0,
    RS_FILTER_CAL = 3'h1,
    RS_SLEEP      = 3'h2,
    RS_OSC_CAL    = 3'h3,
    RS_TX         = 3'h4,
    RS_RX         = 3'h5,
    RS_RETUNE_A   = 3'h6,
    RS_RETUNE_B   = 3'h7
  } slcal_radio_t;

endpackage : slcal_pkg

// >>> rtl/slcal_tick_if.sv
// Purpose: carries sleep source settings down and the sleep tick back up
// Assumes: single aclk domain on both ends
// Notes:   tick is a one-cycle pulse per divided sleep period
`timescale 1ns/100ps
interface slcal_tick_if;
  import slcal_pkg::*;
  logic [SEL_W-1:0] src_sel;
  logic [DIV_W-1:0] divisor;
  logic             tick;
  modport gen  (input src_sel, input divisor, output tick);
  modport user (output src_sel, output divisor, input tick);
endinterface : slcal_tick_if

// >>> rtl/slcal_sleep_tick.sv
// Purpose: turns the selected, divided sleep source into a sleep tick pulse
// Assumes: oscillator inputs are asynchronous and much slower than aclk
// Notes:   source code 00 or 11 gives no tick at all
`timescale 1ns/100ps
module slcal_sleep_tick
  import slcal_pkg::*;
(
  input  wire logic   aclk,
  input  wire logic   aresetn,
  input  wire logic   osc_ext,
  input  wire logic   osc_int,
  slcal_tick_if.gen   tif
);

  logic [1:0]        raw;
  logic [1:0]        rise;
  logic              sel_edge;
  logic [EDGE_W-1:0] edge_cnt;
  logic [EDGE_W-1:0] div_mask;
  logic              tick;

  assign raw = {osc_int, osc_ext};

  // three-stage sync
  // a change counts once stages two and three agree
  for (genvar g = 0; g < 2; g++) begin : g_sync
    logic s1, s2, s3, stable;
    always_ff @(posedge aclk) begin
      if (!aresetn) begin
        s1     <= 1'b0;
        s2     <= 1'b0;
        s3     <= 1'b0;
        stable <= 1'b0;
      end else begin
        s1     <= raw[g];
        s2     <= s1;
        s3     <= s2;
        stable <= (s2 == s3) ? s3 : stable;
      end
    end
    assign rise[g] = (s2 == s3) && s3 && !stable;
  end

  assign sel_edge = (tif.src_sel == SRC_INT) ? rise[1] :
                    (tif.src_sel == SRC_EXT) ? rise[0] : 1'b0;

  // divide by two to the n
  assign div_mask = EDGE_W'((32'h1 << tif.divisor) - 32'h1);

  // free-running edge count; phase needs no reset on setting change
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      edge_cnt <= '0;
      tick     <= 1'b0;
    end else begin
      edge_cnt <= sel_edge ? edge_cnt + 1'b1 : edge_cnt;
      tick     <= sel_edge && ((edge_cnt & div_mask) == '0);
    end
  end

  assign tif.tick = tick;

  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  a_tick_single_pulse: assert property (tick |=> !tick)
    else $error("sleep tick longer than one cycle");

  a_div_zero_every: assert property ((tif.divisor == '0) && sel_edge |=> tick)
    else $error("undivided edge gave no tick");

endmodule : slcal_sleep_tick

// >>> rtl/slcal_top.sv
// Purpose: sleep clock calibration counter and radio state readout, AXI4-Lite slave
// Assumes: aclk 50 MHz, synchronous active-low reset, radio state on same clock
// Notes:   counter ticks are 50 ns, generated from aclk by a phase accumulator
//
// Function
// - writing one to start bit 4 begins calibration; bit self-clears when done
// - done flag at bit 7 sets when the count finishes
// - result is a 20-bit counter readable by software
// - counter spans exactly sixteen consecutive sleep tick periods
// - each count step is one 50 ns reference tick
// - measured period follows source selection and divisor settings
// - counter bits 19..16 read in status bits 3..0 at 0x20b
// - read-only 0x20f shows radio state in bits 7..5, rest zero
// - counter bits 7..0 at 0x209, 15..8 at 0x20a, read-only, reset zero
// - source code 10 picks internal oscillator, 01 external crystal
// - selected source divided by two to the divisor; divisor resets zero
`timescale 1ns/100ps
module slcal_top
  import slcal_pkg::*;
(
  input  wire logic                  aclk,
  input  wire logic                  aresetn,
  input  wire slcal_pkg::slcal_addr_t s_axi_awaddr,
  input  wire logic [2:0]            s_axi_awprot,
  input  wire logic                  s_axi_awvalid,
  output logic                       s_axi_awready,
  input  wire slcal_pkg::slcal_data_t s_axi_wdata,
  input  wire logic [3:0]            s_axi_wstrb,
  input  wire logic                  s_axi_wvalid,
  output logic                       s_axi_wready,
  output logic [1:0]                 s_axi_bresp,
  output logic                       s_axi_bvalid,
  input  wire logic                  s_axi_bready,
  input  wire slcal_pkg::slcal_addr_t s_axi_araddr,
  input  wire logic [2:0]            s_axi_arprot,
  input  wire logic                  s_axi_arvalid,
  output logic                       s_axi_arready,
  output slcal_pkg::slcal_data_t     s_axi_rdata,
  output logic [1:0]                 s_axi_rresp,
  output logic                       s_axi_rvalid,
  input  wire logic                  s_axi_rready,
  input  wire logic                  osc_ext,
  input  wire logic                  osc_int,
  input  wire slcal_pkg::slcal_radio_t radio_fsm_state,
  output logic                       irq
);

  // write channel state
  logic             aw_got, w_got;
  slcal_idx_t       wr_idx;
  logic [7:0]       wr_byte;
  logic             wr_lane0;
  // register state
  logic [SEL_W-1:0] sleep_src_select;
  logic [DIV_W-1:0] sleep_divisor;
  logic [7:0]       int_status, int_mask;
  // calibration state
  slcal_state_t     state, next_state;
  logic [CNT_W-1:0] cal_count;
  logic [PER_W-1:0] period_cnt;
  logic             cal_done_flag;
  logic [PH_W-1:0]  phase;
  logic             ref_tick;

  slcal_tick_if tif ();

  slcal_sleep_tick u_tick (
    .aclk    (aclk),
    .aresetn (aresetn),
    .osc_ext (osc_ext),
    .osc_int (osc_int),
    .tif     (tif)
  );

  // settings feed the tick generator live
  assign tif.src_sel = sleep_src_select;
  assign tif.divisor = sleep_divisor;

  // write decode
  wire aw_hs     = s_axi_awvalid && s_axi_awready;
  wire w_hs      = s_axi_wvalid && s_axi_wready;
  wire do_write  = aw_got && w_got && !s_axi_bvalid;
  wire wr_ok     = wr_lane0;
  wire wr_sel    = do_write && wr_ok && (wr_idx == IDX_SRC_SEL);
  wire wr_div    = do_write && wr_ok && (wr_idx == IDX_DIVISOR);
  wire wr_istat  = do_write && wr_ok && (wr_idx == IDX_INT_STAT);
  wire wr_imask  = do_write && wr_ok && (wr_idx == IDX_INT_MASK);
  wire wr_known  = (wr_idx == IDX_SRC_SEL) || (wr_idx == IDX_CAL_LOW) ||
                   (wr_idx == IDX_CAL_MID) || (wr_idx == IDX_STATUS) ||
                   (wr_idx == IDX_RADIO) || (wr_idx == IDX_DIVISOR) ||
                   (wr_idx == IDX_INT_STAT) || (wr_idx == IDX_INT_MASK);
  // reserved bits 6..5 are simply dropped
  wire start_pulse = do_write && wr_ok && (wr_idx == IDX_STATUS) && wr_byte[START_BIT];

  // address and data may come in either order; both are held until the write
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_got        <= 1'b0;
      s_axi_awready <= 1'b1;
      wr_idx        <= '0;
    end else if (aw_hs) begin
      aw_got        <= 1'b1;
      s_axi_awready <= 1'b0;
      wr_idx        <= s_axi_awaddr[ADDR_W-1:2];
    end else begin
      aw_got        <= do_write ? 1'b0 : aw_got;
      s_axi_awready <= (s_axi_bvalid && s_axi_bready) ? 1'b1 : s_axi_awready;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      w_got        <= 1'b0;
      s_axi_wready <= 1'b1;
      wr_byte      <= '0;
      wr_lane0     <= 1'b0;
    end else if (w_hs) begin
      w_got        <= 1'b1;
      s_axi_wready <= 1'b0;
      wr_byte      <= s_axi_wdata[7:0];
      wr_lane0     <= s_axi_wstrb[0];
    end else begin
      w_got        <= do_write ? 1'b0 : w_got;
      s_axi_wready <= (s_axi_bvalid && s_axi_bready) ? 1'b1 : s_axi_wready;
    end
  end

  // write response, unmapped index answers slverr
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= RESP_OKAY;
    end else if (do_write) begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp  <= wr_known ? RESP_OKAY : RESP_SLVERR;
    end else if (s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      sleep_src_select <= SEL_RESET;
      sleep_divisor    <= DIV_RESET;
    end else begin
      sleep_src_select <= wr_sel ? wr_byte[SEL_LSB +: SEL_W] : sleep_src_select;
      sleep_divisor    <= wr_div ? wr_byte[DIV_W-1:0] : sleep_divisor;
    end
  end

  // 50 ns reference tick, 2 ticks per 5 clocks
  wire [PH_W-1:0] ph_sum  = phase + PH_STEP;
  wire            ph_wrap = ph_sum >= PH_WRAP;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      phase    <= '0;
      ref_tick <= 1'b0;
    end else begin
      phase    <= ph_wrap ? ph_sum - PH_WRAP : ph_sum;
      ref_tick <= ph_wrap;
    end
  end

  // arm on a tick, then count sixteen periods
  wire sl_tick    = tif.tick;
  wire last_tick  = (state == ST_COUNT) && sl_tick && (period_cnt == LAST_PERIOD);
  wire cal_finish = last_tick && !start_pulse;
  always_comb begin
    next_state = state;
    case (state)
      ST_IDLE:  next_state = start_pulse ? ST_ARM : ST_IDLE;
      ST_ARM:   next_state = (!start_pulse && sl_tick) ? ST_COUNT : ST_ARM;
      ST_COUNT: next_state = start_pulse ? ST_ARM : (last_tick ? ST_IDLE : ST_COUNT);
      default:  next_state = ST_IDLE;
    endcase
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state <= ST_IDLE;
    end else begin
      state <= next_state;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn || state != ST_COUNT) begin
      period_cnt <= '0;
    end else if (sl_tick) begin
      period_cnt <= period_cnt + 1'b1;
    end
  end

  // 20-bit result, saturates rather than wrap on a stalled source
  always_ff @(posedge aclk) begin
    if (!aresetn || start_pulse) begin
      cal_count <= '0;
    end else if (state == ST_COUNT && ref_tick && cal_count != CNT_MAX) begin
      cal_count <= cal_count + 1'b1;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn || start_pulse) begin
      cal_done_flag <= 1'b0;
    end else if (cal_finish) begin
      cal_done_flag <= 1'b1;
    end
  end

  // interrupt status, write one to clear, a completion beats the clear
  wire [7:0] int_set = {7'h00, cal_finish} << INT_DONE;
  wire [7:0] int_clr = wr_istat ? wr_byte : 8'h00;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      int_status <= 8'h00;
      int_mask   <= 8'h00;
      irq        <= 1'b0;
    end else begin
      int_status <= (int_status & ~int_clr) | int_set;
      int_mask   <= wr_imask ? wr_byte : int_mask;
      irq        <= |(int_status & int_mask);
    end
  end

  // start bit reads one while a measurement is under way
  wire cal_start_bit = (state != ST_IDLE);
  wire [7:0] status_byte = {cal_done_flag, 2'h0, cal_start_bit, cal_count[CNT_W-1:16]};
  wire [7:0] radio_byte  = {radio_fsm_state, 5'h00};

  // read decode
  wire        ar_hs  = s_axi_arvalid && s_axi_arready;
  slcal_idx_t rd_idx;
  assign rd_idx = s_axi_araddr[ADDR_W-1:2];
  logic [7:0] rd_byte;
  logic       rd_known;
  always_comb begin
    rd_known = 1'b1;
    if (rd_idx == IDX_SRC_SEL) begin
      rd_byte = {sleep_src_select, 6'h00};
    end else if (rd_idx == IDX_CAL_LOW) begin
      rd_byte = cal_count[7:0];
    end else if (rd_idx == IDX_CAL_MID) begin
      rd_byte = cal_count[15:8];
    end else if (rd_idx == IDX_STATUS) begin
      rd_byte = status_byte;
    end else if (rd_idx == IDX_RADIO) begin
      rd_byte = radio_byte;
    end else if (rd_idx == IDX_DIVISOR) begin
      rd_byte = {3'h0, sleep_divisor};
    end else if (rd_idx == IDX_INT_STAT) begin
      rd_byte = int_status;
    end else if (rd_idx == IDX_INT_MASK) begin
      rd_byte = int_mask;
    end else begin
      rd_byte  = 8'h00;
      rd_known = 1'b0;
    end
  end

  // read data is captured at the address handshake
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= '0;
      s_axi_rresp   <= RESP_OKAY;
    end else if (ar_hs) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b1;
      s_axi_rdata   <= {24'h000000, rd_byte};
      s_axi_rresp   <= rd_known ? RESP_OKAY : RESP_SLVERR;
    end else if (s_axi_rvalid && s_axi_rready) begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid  <= 1'b0;
    end
  end

  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  a_start_clears_old: assert property (start_pulse |=> !cal_done_flag && cal_count == '0)
    else $error("start left old result");

  a_busy_after_start: assert property (start_pulse |=> cal_start_bit)
    else $error("start bit not set after start");

  a_start_self_clear: assert property ($rose(cal_done_flag) |-> !cal_start_bit)
    else $error("start bit still set at done");

  a_done_sixteen: assert property ($rose(cal_done_flag) |-> $past(period_cnt) == LAST_PERIOD && $past(sl_tick))
    else $error("done not after sixteenth period");

  a_count_only_ref: assert property (state == ST_COUNT && !ref_tick && !start_pulse |=> $stable(cal_count))
    else $error("count moved without reference tick");

  a_ref_tick_rate: assert property (ref_tick |=> !ref_tick ##[1:2] ref_tick)
    else $error("reference tick spacing wrong");

  a_status_layout: assert property (ar_hs && rd_idx == IDX_STATUS |=>
      s_axi_rdata[3:0] == $past(cal_count[19:16]) && s_axi_rdata[6:5] == 2'h0)
    else $error("status byte layout wrong");

  a_radio_readout: assert property (ar_hs && rd_idx == IDX_RADIO |=>
      s_axi_rdata[7:5] == $past(radio_fsm_state) && s_axi_rdata[4:0] == 5'h00)
    else $error("radio state readout wrong");

  a_done_set_wins: assert property (cal_finish && wr_istat |=> int_status[INT_DONE])
    else $error("done event lost to clear");

  a_irq_follows: assert property (int_status[INT_DONE] && int_mask[INT_DONE] |=> irq)
    else $error("unmasked status gave no interrupt");

  c_full_cal:  cover property ($rose(cal_done_flag));
  c_restart:   cover property (start_pulse && state == ST_COUNT);
  c_unmapped:  cover property (s_axi_rvalid && s_axi_rresp == RESP_SLVERR);
  c_w_first:   cover property (w_hs && !aw_got && !aw_hs);

endmodule : slcal_top

// >>> bench/slcal_top_tb_top.sv
// Purpose: self-checking bench for the sleep clock calibration block over AXI4-Lite
// Assumes: 50 MHz aclk, synchronous active-low reset, one register byte per word
// Notes:   external source runs ten times faster than a real crystal to keep runs short
`timescale 1ns/100ps
module slcal_top_tb_top;
  import slcal_pkg::*;

  // one comparison, counted, mismatch reported at once
  `define CHK(nm, e, g) begin checks++; if ((g) !== (e)) begin fail_count++; \
    $display("[FAIL] %s expected %0h seen %0h", nm, e, g); end end

  localparam real INT_HALF = 5000.0;   // 100 kHz internal source
  localparam real EXT_HALF = 1562.5;   // scaled external source, 320 kHz
  logic         aclk, aresetn, awvalid, wvalid, bready, arvalid, rready;
  logic         awready, wready, bvalid, arready, rvalid, osc_ext, osc_int, irq;
  logic [1:0]   bresp, rresp;
  slcal_addr_t  awaddr, araddr;
  slcal_data_t  wdata, rdata;
  slcal_radio_t radio;
  int           fail_count, checks;

  slcal_top u_dut (
    .aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr), .s_axi_awprot(3'h0),
    .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'h1),
    .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
    .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arprot(3'h0), .s_axi_arvalid(arvalid),
    .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
    .s_axi_rready(rready), .osc_ext(osc_ext), .osc_int(osc_int), .radio_fsm_state(radio), .irq(irq)
  );

  // free-running clocks, osc_int edges land on aclk falling edges, osc_ext drifts in phase to aclk
  initial begin
    aclk = 1'b0;
    forever #10 aclk = ~aclk;
  end
  initial begin
    osc_int = 1'b0;
    forever #(INT_HALF) osc_int = ~osc_int;
  end
  initial begin
    osc_ext = 1'b0;
    #777;
    forever #(EXT_HALF) osc_ext = ~osc_ext;
  end

  function automatic slcal_addr_t adr(input slcal_idx_t i);
    return {i, 2'b00};
  endfunction : adr

  task automatic end_of_test;
    $display("checks %0d fail_count %0d", checks, fail_count);
    if (fail_count == 0 && checks > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask : end_of_test

  // write: address and data offered together, each dropped when taken
  task automatic axi_wr(input slcal_addr_t a, input logic [7:0] d, output logic [1:0] r);
    int n;
    @(posedge aclk);
    awaddr  <= a;
    wdata   <= {24'h0, d};
    awvalid <= 1'b1;
    wvalid  <= 1'b1;
    bready  <= 1'b1;
    for (n = 0; n < 200; n++) begin
      @(posedge aclk);
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
      if (bvalid === 1'b1) begin
        r = bresp;
        bready <= 1'b0;
        break;
      end
    end
    if (n >= 200) begin
      fail_count++;
      end_of_test();
    end
  endtask : axi_wr

  // read: hold address until taken, rready until rvalid seen
  task automatic axi_rd(input slcal_addr_t a, output slcal_data_t d, output logic [1:0] r);
    int n;
    @(posedge aclk);
    araddr  <= a;
    arvalid <= 1'b1;
    rready  <= 1'b1;
    for (n = 0; n < 200; n++) begin
      @(posedge aclk);
      if (arvalid && arready) arvalid <= 1'b0;
      if (rvalid === 1'b1) begin
        d = rdata;
        r = rresp;
        rready <= 1'b0;
        break;
      end
    end
    if (n >= 200) begin
      fail_count++;
      end_of_test();
    end
  endtask : axi_rd

  // one calibration with given source, divisor and mask; exp in 50 ns ticks; again restarts it mid-count
  task automatic run_cal(input logic [7:0] sel, input logic [4:0] dv, input logic mk, input int exp,
                         input logic again);
    slcal_data_t d, lo, mi;
    logic [1:0]  rs;
    logic [19:0] cnt;
    int          n;
    axi_wr(adr(IDX_INT_MASK), {7'h0, mk}, rs);
    axi_wr(adr(IDX_SRC_SEL), sel, rs);
    axi_wr(adr(IDX_DIVISOR), {3'h0, dv}, rs);
    axi_rd(adr(IDX_DIVISOR), d, rs);
    `CHK("divisor", {27'h0, dv}, d)
    axi_rd(adr(IDX_SRC_SEL), d, rs);
    `CHK("src_sel", {24'h0, sel}, d)
    // start with reserved bits kept at zero
    axi_wr(adr(IDX_STATUS), 8'h10, rs);
    `CHK("start_resp", RESP_OKAY, rs)
    axi_rd(adr(IDX_STATUS), d, rs);
    `CHK("status_busy", 32'h0000_0010, d)
    axi_rd(adr(IDX_CAL_MID), d, rs);
    `CHK("old_count_cleared", 32'h0, d)
    // restart once the count has clearly moved; the partial count must vanish
    if (again) begin
      n = 0;
      do begin
        axi_rd(adr(IDX_CAL_LOW), d, rs);
        n++;
      end while (d[7:6] === 2'h0 && n < 2000);
      if (n >= 2000) begin
        fail_count++;
        end_of_test();
      end
      axi_wr(adr(IDX_STATUS), 8'h10, rs);
      axi_rd(adr(IDX_CAL_LOW), d, rs);
      `CHK("restart_cleared", 1'b1, d < 32'h8)
    end
    n = 0;
    do begin
      axi_rd(adr(IDX_STATUS), d, rs);
      n++;
    end while (d[DONE_BIT] !== 1'b1 && n < 20000);
    if (n >= 20000) begin
      fail_count++;
      end_of_test();
    end
    `CHK("status_done", 4'h8, d[7:4])
    axi_rd(adr(IDX_CAL_LOW), lo, rs);
    axi_rd(adr(IDX_CAL_MID), mi, rs);
    cnt = {d[3:0], mi[7:0], lo[7:0]};
    // phase alignment of the sleep tick allows a small error either way
    `CHK("count_range", 1'b1, (cnt >= 20'(exp - 2) && cnt <= 20'(exp + 2)))
    `CHK("irq_done", mk, irq)
    axi_rd(adr(IDX_INT_STAT), d, rs);
    `CHK("int_status_set", 32'h1, d)
    axi_wr(adr(IDX_INT_STAT), 8'h01, rs);
    axi_rd(adr(IDX_INT_STAT), d, rs);
    `CHK("int_status_clear", 32'h0, d)
    `CHK("irq_clear", 1'b0, irq)
  endtask : run_cal

  slcal_idx_t  rst_idx [8] = '{IDX_SRC_SEL, IDX_CAL_LOW, IDX_CAL_MID, IDX_STATUS,
                               IDX_RADIO, IDX_DIVISOR, IDX_INT_STAT, IDX_INT_MASK};
  slcal_data_t d;
  logic [1:0]  rs;

  // main sequence
  initial begin
    fail_count = 0;
    checks     = 0;
    aresetn    = 1'b0;
    awvalid    = 1'b0;
    wvalid     = 1'b0;
    bready     = 1'b0;
    arvalid    = 1'b0;
    rready     = 1'b0;
    awaddr     = '0;
    araddr     = '0;
    wdata      = '0;
    radio      = RS_RESET;
    repeat (8) @(posedge aclk);
    aresetn <= 1'b1;
    // every register reads zero after reset
    foreach (rst_idx[i]) begin
      axi_rd(adr(rst_idx[i]), d, rs);
      `CHK("reset_value", 32'h0, d)
      `CHK("reset_resp", RESP_OKAY, rs)
    end
    `CHK("irq_reset", 1'b0, irq)
    // all eight radio state codes in bits 7..5
    for (int i = 0; i < 8; i++) begin
      @(posedge aclk);
      radio <= slcal_radio_t'(i);
      axi_rd(adr(IDX_RADIO), d, rs);
      `CHK("radio_state", {24'h0, 3'(i), 5'h0}, d)
    end
    // read-only places ignore writes
    axi_wr(adr(IDX_RADIO), 8'hff, rs);
    axi_wr(adr(IDX_CAL_LOW), 8'hff, rs);
    axi_rd(adr(IDX_RADIO), d, rs);
    `CHK("radio_ro", 32'h0000_00e0, d)
    axi_rd(adr(IDX_CAL_LOW), d, rs);
    `CHK("count_ro", 32'h0, d)
    // unmapped index answers with an error
    axi_wr(12'h800, 8'h5a, rs);
    `CHK("unmapped_bresp", RESP_SLVERR, rs)
    axi_rd(12'h800, d, rs);
    `CHK("unmapped_rresp", RESP_SLVERR, rs)
    `CHK("unmapped_rdata", 32'h0, d)
    // internal source, divisor 0 and 1, then external source masked
    run_cal(8'h80, 5'h00, 1'b1, 3200, 1'b0);
    run_cal(8'h80, 5'h01, 1'b1, 6400, 1'b0);
    run_cal(8'h40, 5'h02, 1'b0, 4000, 1'b0);
    // restart in mid-count: result must be one fresh sixteen-period measurement
    run_cal(8'h80, 5'h00, 1'b1, 3200, 1'b1);
    // no source selected: measurement never finishes
    axi_wr(adr(IDX_SRC_SEL), 8'h00, rs);
    axi_wr(adr(IDX_STATUS), 8'h10, rs);
    repeat (2000) @(posedge aclk);
    axi_rd(adr(IDX_STATUS), d, rs);
    `CHK("no_source_busy", 32'h0000_0010, d)
    // code 11 selects nothing either
    axi_wr(adr(IDX_SRC_SEL), 8'hc0, rs);
    repeat (2000) @(posedge aclk);
    axi_rd(adr(IDX_STATUS), d, rs);
    `CHK("code11_busy", 32'h0000_0010, d)
    end_of_test();
  end

endmodule : slcal_top_tb_top
